// File: design/mbcc_pkg.sv
// Purpose: shared constants for the memory bank cycle configuration block
// Assumes: 50 MHz sys_clk, six configuration cache entries
// Notes: timing codes, access kinds and state codes live here
package mbcc_pkg;
  localparam int unsigned MBCC_NBANK = 6;
  localparam logic [2:0] MBCC_NBANK_W = 3'h6;
  // cycle timing codes
  localparam logic [3:0] CT_EDO_PIPE1 = 4'h0;
  localparam logic [3:0] CT_EDO_1 = 4'h1;
  localparam logic [3:0] CT_EDO_2 = 4'h2;
  localparam logic [3:0] CT_EDO_3 = 4'h3;
  localparam logic [3:0] CT_SSRAM_1 = 4'h4;
  localparam logic [3:0] CT_ASRAM_1 = 4'h5;
  localparam logic [3:0] CT_ASRAM_2 = 4'h6;
  localparam logic [3:0] CT_ASRAM_3 = 4'h7;
  localparam logic [3:0] CT_SD_BL1_L2 = 4'h8;
  localparam logic [3:0] CT_SD_BL1_L4 = 4'hA;
  localparam logic [3:0] CT_RSVD_A = 4'hB;
  localparam logic [3:0] CT_SD_BL2_L2 = 4'hC;
  localparam logic [3:0] CT_SD_BL2_L4 = 4'hE;
  localparam logic [3:0] CT_RSVD_B = 4'hF;
  localparam logic [1:0] SD_LAT_BASE = 2'h2;
  // access kinds, equal to the row-time access type code
  localparam logic [1:0] KIND_READ = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_PDT_RD = 2'h2;
  localparam logic [1:0] KIND_PDT_WR = 2'h3;
  localparam logic [3:0] ACC_SRC_ONCHIP = 4'h0;
  // address shifting
  localparam logic [4:0] ROW_SHIFT_BASE = 5'h07;
  localparam int unsigned RCA_W = 17;
  // exception handling
  localparam logic [3:0] EXC_WAIT = 4'h3;
  localparam logic [1:0] EXC_NONE = 2'h0;
  // cache entry reset values: reserved timing keeps the bank unusable until loaded
  localparam logic [3:0] CFG_CT_RST = CT_RSVD_B;
  localparam logic [1:0] CFG_TO_RST = 2'h0;
  localparam logic [2:0] CFG_AS_RST = 3'h0;
  localparam logic [1:0] CFG_BS_RST = 2'h3;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ROW = 6'h02,
    ST_EXC = 6'h04,
    ST_COL = 6'h08,
    ST_RTO = 6'h10,
    ST_TOFF = 6'h20
  } mbcc_state_t;
endpackage

// File: design/mbcc_rca_mux.sv
// Purpose: row/column address multiplexer for the shared address lines
// Assumes: byte address already held by the caller
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
module mbcc_rca_mux
  import mbcc_pkg::*;
(
  // address and bank settings
  input wire logic [31:0] byte_addr,
  input wire logic [2:0] row_addr_shift,
  input wire logic [1:0] bank_bus_width,
  input wire logic row_phase,
  // multiplexed address
  output logic [RCA_W-1:0] rca
);
  logic [4:0] col_lsb;
  logic [4:0] row_lsb;
  logic [4:0] sel_lsb;
  logic [63:0] wide;

  // column start follows the bus width only
  assign col_lsb = {3'h0, bank_bus_width};
  // shift zero keeps the column address at row time
  assign row_lsb = (row_addr_shift == 3'h0) ? col_lsb
    : ROW_SHIFT_BASE + {2'h0, row_addr_shift} + {3'h0, bank_bus_width};
  assign sel_lsb = row_phase ? row_lsb : col_lsb;
  // bits above 31 come out as zero; nothing outside may depend on them
  assign wide = {32'h0, byte_addr} >> sel_lsb;
  assign rca = wide[RCA_W-1:0];
endmodule // mbcc_rca_mux

// File: design/mbcc_cycle_ctrl.sv
// Purpose: per-bank external memory cycle shaping and address multiplexing
// Assumes: configuration cache entries are written through the cfg load port
// Notes: one access at a time; pins are registered from the next state, in step with the state register
`timescale 1ns/1ps
module mbcc_cycle_ctrl
  import mbcc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // configuration cache load
  input wire logic cfg_load,
  input wire logic [2:0] cfg_bank,
  input wire logic [3:0] cfg_cycle_timing_sel,
  input wire logic [1:0] cfg_extra_turnoff_count,
  input wire logic cfg_exc_en,
  input wire logic [2:0] cfg_row_addr_shift,
  input wire logic [1:0] cfg_bank_bus_width,
  // access request
  input wire logic req_valid,
  input wire logic [2:0] req_bank,
  input wire logic [31:0] req_addr,
  input wire logic [1:0] req_kind,
  input wire logic [63:0] req_wdata,
  // access status
  output logic req_ready,
  output logic done_pulse,
  output logic cfg_err,
  output logic exc_abort,
  output logic [1:0] exc_code,
  output logic [63:0] rd_data,
  // memory pins
  input wire logic [1:0] except_in,
  input wire logic [63:0] ad_i,
  output logic [63:0] ad_o,
  output logic ad_oe,
  output logic [RCA_W-1:0] muxed_row_col_addr,
  output logic row_time,
  output logic col_time
);
  // configuration cache
  logic [3:0] cfg_ct_r [MBCC_NBANK];
  logic [1:0] cfg_to_r [MBCC_NBANK];
  logic cfg_e_r [MBCC_NBANK];
  logic [2:0] cfg_as_r [MBCC_NBANK];
  logic [1:0] cfg_bs_r [MBCC_NBANK];
  // latched access
  logic [31:0] acc_addr_r;
  logic [31:0] acc_addr_nxt;
  logic [1:0] acc_kind_r;
  logic [1:0] acc_kind_nxt;
  logic [63:0] acc_wdata_r;
  logic [63:0] acc_wdata_nxt;
  logic [3:0] acc_ct_r;
  logic [3:0] acc_ct_nxt;
  logic [1:0] acc_to_r;
  logic [1:0] acc_to_nxt;
  logic acc_e_r;
  logic acc_e_nxt;
  logic [2:0] acc_as_r;
  logic [2:0] acc_as_nxt;
  logic [1:0] acc_bs_r;
  logic [1:0] acc_bs_nxt;
  // sequencing
  mbcc_state_t state_r;
  mbcc_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [1:0] exc_s1_r;
  logic [1:0] exc_s2_r;
  logic [63:0] ad_s1_r;
  logic [63:0] ad_s2_r;
  // output flops
  logic req_ready_r;
  logic done_r;
  logic cfg_err_r;
  logic exc_abort_r;
  logic [1:0] exc_code_r;
  logic [63:0] rd_data_r;
  logic [63:0] ad_o_r;
  logic ad_oe_r;
  logic [RCA_W-1:0] rca_r;
  logic row_time_r;
  logic col_time_r;

  // timing code decoding
  function automatic logic ct_valid(input logic [3:0] ct);
    ct_valid = (ct != CT_RSVD_A) && (ct != CT_RSVD_B);
  endfunction

  function automatic logic [2:0] ct_col_cycles(input logic [3:0] ct, input logic rd);
    logic [2:0] n;
    n = 3'h1;
    if (ct[3])
    begin
      // sdram: reads wait out the latency, writes take one cycle
      n = rd ? {1'b0, ct[1:0]} + {1'b0, SD_LAT_BASE} : 3'h1;
    end
    else if (ct[1:0] == 2'h2)
    begin
      n = 3'h2;
    end
    else if (ct[1:0] == 2'h3)
    begin
      n = 3'h3;
    end
    ct_col_cycles = n;
  endfunction

  function automatic logic [3:0] ct_total(input logic [3:0] ct, input logic rd);
    logic [2:0] cpc;
    cpc = ct_col_cycles(ct, rd);
    // burst length two doubles the column phase
    ct_total = (ct[3] && ct[2]) ? {cpc, 1'b0} : {1'b0, cpc};
  endfunction

  function automatic logic ct_auto_rto(input logic [3:0] ct, input logic rd);
    // non-pipelined edo and async sram reads release the bus late
    ct_auto_rto = rd && !ct[3] && (ct != CT_EDO_PIPE1) && (ct != CT_SSRAM_1);
  endfunction

  // cache load, one process per entry
  genvar gi;
  generate
    for (gi = 0; gi < MBCC_NBANK; gi++)
    begin : g_entry
      always_ff @(posedge sys_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          cfg_ct_r[gi] <= CFG_CT_RST;
          cfg_to_r[gi] <= CFG_TO_RST;
          cfg_e_r[gi] <= 1'b0;
          cfg_as_r[gi] <= CFG_AS_RST;
          cfg_bs_r[gi] <= CFG_BS_RST;
        end
        else if (cfg_load && (cfg_bank == 3'(gi)))
        begin
          cfg_ct_r[gi] <= cfg_cycle_timing_sel;
          cfg_to_r[gi] <= cfg_extra_turnoff_count;
          cfg_e_r[gi] <= cfg_exc_en;
          cfg_as_r[gi] <= cfg_row_addr_shift;
          cfg_bs_r[gi] <= cfg_bank_bus_width;
        end
      end
    end
  endgenerate

  // request acceptance and entry lookup
  wire logic accept = req_valid && (state_r == ST_IDLE);
  wire logic bank_ok = req_bank < MBCC_NBANK_W;
  wire logic [2:0] bank_idx = bank_ok ? req_bank : 3'h0;
  wire logic [3:0] sel_ct = bank_ok ? cfg_ct_r[bank_idx] : CT_RSVD_B;
  wire logic req_bad = !ct_valid(sel_ct);
  wire logic take = accept && !req_bad;
  wire logic acc_rd = (acc_kind_r == KIND_READ) || (acc_kind_r == KIND_PDT_RD);
  wire logic [3:0] col_last = ct_total(acc_ct_r, acc_rd) - 4'h1;
  wire logic rto_need = ct_auto_rto(acc_ct_r, acc_rd);
  // plain writes skip the configured turn-off
  wire logic toff_need = (acc_kind_r != KIND_WRITE) && (acc_to_r != 2'h0);
  wire logic [3:0] toff_last = {2'h0, acc_to_r} - 4'h1;
  wire logic exc_hit = exc_s2_r != EXC_NONE;

  assign acc_addr_nxt = take ? req_addr : acc_addr_r;
  assign acc_kind_nxt = take ? req_kind : acc_kind_r;
  assign acc_wdata_nxt = take ? req_wdata : acc_wdata_r;
  assign acc_ct_nxt = take ? sel_ct : acc_ct_r;
  assign acc_to_nxt = take ? cfg_to_r[bank_idx] : acc_to_r;
  assign acc_e_nxt = take ? cfg_e_r[bank_idx] : acc_e_r;
  assign acc_as_nxt = take ? cfg_as_r[bank_idx] : acc_as_r;
  assign acc_bs_nxt = take ? cfg_bs_r[bank_idx] : acc_bs_r;

  // cycle sequencer
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE:
      begin
        if (take)
        begin
          state_nxt = ST_ROW;
        end
      end
      ST_ROW:
      begin
        if (acc_e_r)
        begin
          state_nxt = ST_EXC;
          cnt_nxt = EXC_WAIT - 4'h1;
        end
        else
        begin
          state_nxt = ST_COL;
          cnt_nxt = col_last;
        end
      end
      ST_EXC:
      begin
        if (cnt_r != 4'h0)
        begin
          cnt_nxt = cnt_r - 4'h1;
        end
        else if (exc_hit)
        begin
          state_nxt = ST_IDLE;
        end
        else
        begin
          state_nxt = ST_COL;
          cnt_nxt = col_last;
        end
      end
      ST_COL:
      begin
        if (cnt_r != 4'h0)
        begin
          cnt_nxt = cnt_r - 4'h1;
        end
        else if (rto_need)
        begin
          state_nxt = ST_RTO;
        end
        else if (toff_need)
        begin
          state_nxt = ST_TOFF;
          cnt_nxt = toff_last;
        end
        else
        begin
          state_nxt = ST_IDLE;
        end
      end
      ST_RTO:
      begin
        // configured states follow the automatic one
        if (toff_need)
        begin
          state_nxt = ST_TOFF;
          cnt_nxt = toff_last;
        end
        else
        begin
          state_nxt = ST_IDLE;
        end
      end
      ST_TOFF:
      begin
        if (cnt_r != 4'h0)
        begin
          cnt_nxt = cnt_r - 4'h1;
        end
        else
        begin
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
        cnt_nxt = 4'h0;
      end
    endcase
  end

  // pin values for the coming state
  wire logic row_nxt = state_nxt == ST_ROW;
  wire logic col_nxt = state_nxt == ST_COL;
  wire logic drive_wr = col_nxt && (acc_kind_nxt == KIND_WRITE);
  wire logic [63:0] row_word = {24'h0, ACC_SRC_ONCHIP, 2'h0, acc_kind_nxt, acc_addr_nxt};
  wire logic [63:0] ad_nxt = row_nxt ? row_word : (drive_wr ? acc_wdata_nxt : 64'h0);
  wire logic ab_nxt = (state_r == ST_EXC) && (cnt_r == 4'h0) && exc_hit;
  wire logic dn_nxt = (state_r != ST_IDLE) && (state_nxt == ST_IDLE) && !ab_nxt;
  wire logic cap_rd = (state_r == ST_COL) && (cnt_r == 4'h0) && acc_rd;
  logic [RCA_W-1:0] rca_nxt;

  mbcc_rca_mux u_rca
  (
    .byte_addr(acc_addr_nxt),
    .row_addr_shift(acc_as_nxt),
    .bank_bus_width(acc_bs_nxt),
    .row_phase(row_nxt),
    .rca(rca_nxt)
  );

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      exc_s1_r <= 2'h0;
      exc_s2_r <= 2'h0;
      ad_s1_r <= 64'h0;
      ad_s2_r <= 64'h0;
    end
    else
    begin
      exc_s1_r <= except_in;
      exc_s2_r <= exc_s1_r;
      ad_s1_r <= ad_i;
      ad_s2_r <= ad_s1_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      acc_addr_r <= 32'h0;
      acc_kind_r <= KIND_READ;
      acc_wdata_r <= 64'h0;
      acc_ct_r <= CFG_CT_RST;
      acc_to_r <= CFG_TO_RST;
      acc_e_r <= 1'b0;
      acc_as_r <= CFG_AS_RST;
      acc_bs_r <= CFG_BS_RST;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      acc_addr_r <= acc_addr_nxt;
      acc_kind_r <= acc_kind_nxt;
      acc_wdata_r <= acc_wdata_nxt;
      acc_ct_r <= acc_ct_nxt;
      acc_to_r <= acc_to_nxt;
      acc_e_r <= acc_e_nxt;
      acc_as_r <= acc_as_nxt;
      acc_bs_r <= acc_bs_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req_ready_r <= 1'b0;
      done_r <= 1'b0;
      cfg_err_r <= 1'b0;
      exc_abort_r <= 1'b0;
      exc_code_r <= EXC_NONE;
      rd_data_r <= 64'h0;
      ad_o_r <= 64'h0;
      ad_oe_r <= 1'b0;
      rca_r <= '0;
      row_time_r <= 1'b0;
      col_time_r <= 1'b0;
    end
    else
    begin
      req_ready_r <= state_nxt == ST_IDLE;
      done_r <= dn_nxt;
      cfg_err_r <= accept && req_bad;
      exc_abort_r <= ab_nxt;
      exc_code_r <= ab_nxt ? exc_s2_r : exc_code_r;
      // data path lags the pins by the synchroniser depth
      rd_data_r <= cap_rd ? ad_s2_r : rd_data_r;
      ad_o_r <= ad_nxt;
      ad_oe_r <= row_nxt || drive_wr;
      rca_r <= rca_nxt;
      row_time_r <= row_nxt;
      col_time_r <= col_nxt;
    end
  end

  assign req_ready = req_ready_r;
  assign done_pulse = done_r;
  assign cfg_err = cfg_err_r;
  assign exc_abort = exc_abort_r;
  assign exc_code = exc_code_r;
  assign rd_data = rd_data_r;
  assign ad_o = ad_o_r;
  assign ad_oe = ad_oe_r;
  assign muxed_row_col_addr = rca_r;
  assign row_time = row_time_r;
  assign col_time = col_time_r;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  logic [3:0] toff_seen_r;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      toff_seen_r <= 4'h0;
    end
    else
    begin
      toff_seen_r <= (state_r == ST_TOFF) ? toff_seen_r + 4'h1 : 4'h0;
    end
  end
  wire logic [4:0] chk_row_lsb = ROW_SHIFT_BASE + {2'h0, acc_as_r} + {3'h0, acc_bs_r};
  wire logic [31:0] chk_col_addr = acc_addr_r >> acc_bs_r;

  chk_reserved_refused: assert property (
    accept && req_bad |=> cfg_err && (state_r == ST_IDLE) && req_ready)
    else $error("reserved timing code was not refused");
  chk_row_addr_low: assert property (
    row_time |-> ad_oe && (ad_o[31:0] == acc_addr_r) && (ad_o[33:32] == acc_kind_r))
    else $error("row time address missing from low bus lines");
  chk_pdt_wr_float: assert property (
    col_time && (acc_kind_r == KIND_PDT_WR) |-> !ad_oe)
    else $error("bus driven during peripheral transfer write");
  chk_write_data: assert property (
    col_time && (acc_kind_r == KIND_WRITE) |-> ad_oe && (ad_o == acc_wdata_r))
    else $error("write data not on bus at column time");
  chk_col_addr_align: assert property (
    col_time |-> muxed_row_col_addr == chk_col_addr[RCA_W-1:0])
    else $error("column address misaligned");
  chk_row_shift_zero: assert property (
    row_time && (acc_as_r == 3'h0) |-> muxed_row_col_addr == chk_col_addr[RCA_W-1:0])
    else $error("unshifted row address differs from column address");
  chk_row_shift_bit: assert property (
    row_time && (acc_as_r != 3'h0) |-> muxed_row_col_addr[0] == acc_addr_r[chk_row_lsb])
    else $error("row address shift wrong");
  chk_no_exc_states: assert property (
    (state_r == ST_ROW) && !acc_e_r |=> (state_r == ST_COL))
    else $error("row time stretched with exceptions off");
  chk_exc_states: assert property (
    (state_r == ST_ROW) && acc_e_r |=> (state_r == ST_EXC)[*3] ##1 (state_r != ST_EXC))
    else $error("exception sampling window wrong");
  chk_toff_count: assert property (
    (state_r == ST_TOFF) && (state_nxt != ST_TOFF) |-> toff_seen_r + 4'h1 == {2'h0, acc_to_r})
    else $error("extra turn-off count wrong");
  chk_write_no_toff: assert property (
    (acc_kind_r == KIND_WRITE) |-> (state_r != ST_TOFF))
    else $error("turn-off added to plain write");
  chk_rto_before_toff: assert property (
    (state_r == ST_RTO) && toff_need |=> (state_r == ST_TOFF))
    else $error("configured turn-off lost after automatic one");

  cov_read_toff: cover property ((state_r == ST_RTO) ##1 (state_r == ST_TOFF));
  cov_exc_abort: cover property (exc_abort);
  cov_sdram_bl2: cover property (col_time && acc_ct_r[3] && acc_ct_r[2]);
  cov_pdt_write: cover property (col_time && (acc_kind_r == KIND_PDT_WR));
endmodule // mbcc_cycle_ctrl

// File: verif/mbcc_mem_model.sv
// Purpose: far-side memory and peripheral on the shared address/data bus
// Assumes: one access at a time, pins changed on the falling edge
// Notes: a released bus shows a pattern that flips every cycle
`timescale 1ns/1ps
module mbcc_mem_model
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // device pins
  input wire logic row_time,
  input wire logic col_time,
  input wire logic [63:0] ad_o,
  input wire logic ad_oe,
  input wire logic [16:0] muxed_row_col_addr,
  output logic [1:0] except_in,
  output logic [63:0] ad_i,
  // scenario knobs
  input wire logic slow,
  input wire logic [1:0] fault_code,
  input wire logic [63:0] mem_word
);
  logic [1:0] kind_r;
  logic col_d;
  logic [1:0] hold_r;
  logic [2:0] exc_r;
  logic [63:0] last_r;
  logic [9:0] dev_addr;
  // a ten-pin device sits on the lowest lines
  assign dev_addr = muxed_row_col_addr[9:0];
  // fault code held from row time through the sampling window
  assign except_in = (exc_r != 3'h0) ? fault_code : 2'h0;
  // device drive wins; returned word is marked with the address on the low lines
  assign ad_i = ad_oe ? ad_o
    : ((hold_r != 2'h0) ? (mem_word ^ {54'h0, dev_addr}) : ~last_r);
  always @(negedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      kind_r <= 2'h0;
      col_d <= 1'b0;
      hold_r <= 2'h0;
      exc_r <= 3'h0;
      last_r <= 64'h0;
    end
    else
    begin
      last_r <= ad_i;
      col_d <= col_time;
      if (row_time)
      begin
        kind_r <= ad_o[33:32];
        exc_r <= 3'h5;
      end
      else if (exc_r != 3'h0)
        exc_r <= exc_r - 3'h1;
      // slow device starts one column cycle late
      if (col_time && (!slow || col_d) && kind_r != 2'h1)
        hold_r <= 2'h3;
      else if (hold_r != 2'h0)
        hold_r <= hold_r - 2'h1;
    end
  end
endmodule // mbcc_mem_model

// File: verif/tb_top.sv
// Purpose: self-checking bench for the bank cycle controller
// Assumes: 50 MHz sys_clk, inputs driven on the falling edge
// Notes: access length counts cycles from the accept edge to the end pulse
`timescale 1ns/1ps
module tb_top
  import mbcc_pkg::*;
;
  logic sys_clk, rst_b, cfg_load, cfg_exc_en, req_valid, slow;
  logic [2:0] cfg_bank, cfg_row_addr_shift, req_bank, end_kind;
  logic [3:0] cfg_cycle_timing_sel;
  logic [1:0] cfg_extra_turnoff_count, cfg_bank_bus_width, req_kind, fault_code;
  logic [1:0] exc_code, except_in;
  logic [31:0] req_addr;
  logic [63:0] req_wdata, mem_word, rd_data, ad_i, ad_o, row_ad, col_ad;
  logic req_ready, done_pulse, cfg_err, exc_abort, ad_oe, row_time, col_time;
  logic row_oe, col_oe;
  logic [16:0] muxed_row_col_addr, row_rca, col_rca;
  int fail_count, checks_done, n, cols, rows;

  mbcc_cycle_ctrl mbcc_cycle_ctrl_inst (.sys_clk, .rst_b, .cfg_load, .cfg_bank,
    .cfg_cycle_timing_sel, .cfg_extra_turnoff_count, .cfg_exc_en, .cfg_row_addr_shift,
    .cfg_bank_bus_width, .req_valid, .req_bank, .req_addr, .req_kind, .req_wdata,
    .req_ready, .done_pulse, .cfg_err, .exc_abort, .exc_code, .rd_data, .except_in,
    .ad_i, .ad_o, .ad_oe, .muxed_row_col_addr, .row_time, .col_time);
  mbcc_mem_model mbcc_mem_model_inst (.sys_clk, .rst_b, .row_time, .col_time, .ad_o,
    .ad_oe, .muxed_row_col_addr, .except_in, .ad_i, .slow, .fault_code, .mem_word);

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic compare(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  function automatic int exp_n(logic [3:0] c, logic [1:0] k, logic [1:0] t, logic e);
    logic rd;
    int pc;
    rd = (k == KIND_READ) || (k == KIND_PDT_RD);
    if (c[3])
      pc = (rd ? 2 + c[1:0] : 1) * (c[2] ? 2 : 1);
    else
      pc = (c[1:0] == 2'h0) ? 1 : c[1:0];
    return 2 + (e ? 3 : 0) + pc + ((rd && !c[3] && c[1:0] != 2'h0) ? 1 : 0)
      + ((k != KIND_WRITE) ? t : 0);
  endfunction

  task automatic load(input logic [2:0] b, input logic [3:0] c, input logic [1:0] t,
    input logic e, input logic [2:0] s, input logic [1:0] w);
    @(negedge sys_clk);
    cfg_load = 1'b1;
    {cfg_bank, cfg_cycle_timing_sel, cfg_extra_turnoff_count} = {b, c, t};
    {cfg_exc_en, cfg_row_addr_shift, cfg_bank_bus_width} = {e, s, w};
    @(negedge sys_clk);
    cfg_load = 1'b0;
  endtask

  // one access; records row and first column pins, ends on done, refusal or abort
  task automatic acc(input logic [2:0] b, input logic [31:0] a, input logic [1:0] k);
    int w;
    logic got;
    w = 0;
    got = 1'b0;
    while (req_ready !== 1'b1 && w < 50)
    begin
      @(negedge sys_clk);
      w++;
    end
    req_valid = 1'b1;
    {req_bank, req_addr, req_kind, req_wdata} = {b, a, k, ~a, a};
    @(negedge sys_clk);
    req_valid = 1'b0;
    n = 1;
    cols = 0;
    rows = 0;
    end_kind = 3'h0;
    while (end_kind == 3'h0 && n < 50)
    begin
      cols += (col_time === 1'b1);
      rows += (row_time === 1'b1);
      if (row_time === 1'b1)
        {row_rca, row_ad, row_oe} = {muxed_row_col_addr, ad_o, ad_oe};
      if (col_time === 1'b1 && !got)
      begin
        {col_rca, col_ad, col_oe} = {muxed_row_col_addr, ad_o, ad_oe};
        got = 1'b1;
      end
      end_kind = {exc_abort, cfg_err, done_pulse};
      if (end_kind == 3'h0)
      begin
        @(negedge sys_clk);
        n++;
      end
    end
    if (n >= 50 || w >= 50)
      compare("access finished", 1'b0, 1'b1);
    // refusal ends in the valid-release step; keep valid strokes apart
    if (n == 1)
      @(negedge sys_clk);
  endtask

  initial
  begin
    #400000;
    fail_count++;
    complete_run();
  end

  initial
  begin
    {rst_b, cfg_load, cfg_exc_en, req_valid, slow, fault_code} = 7'h0;
    {cfg_bank, cfg_row_addr_shift, cfg_cycle_timing_sel} = 10'h0;
    {cfg_extra_turnoff_count, cfg_bank_bus_width, req_bank, req_kind} = 9'h0;
    {req_addr, req_wdata, mem_word} = 160'h0;
    fail_count = 0;
    checks_done = 0;
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
    // unloaded entry, both reserved codes, and a bank past the cache
    acc(3'h0, 32'h0, KIND_READ);
    compare("unloaded refusal", {end_kind, n[7:0]}, {3'h2, 8'h1});
    for (int i = 0; i < 2; i++)
    begin
      load(3'h1, i[0] ? CT_RSVD_B : CT_RSVD_A, 2'h0, 1'b0, 3'h0, 2'h3);
      acc(3'h1, 32'h0, KIND_READ);
      compare("reserved refusal", {end_kind, n[7:0]}, {3'h2, 8'h1});
    end
    acc(3'h6, 32'h0, KIND_READ);
    compare("bank range refusal", end_kind, 3'h2);
    // every valid timing code, read and write
    for (int c = 0; c < 16; c++)
      if (c != 11 && c != 15)
        for (int k = 0; k < 2; k++)
        begin
          load(3'h0, c[3:0], 2'h0, 1'b0, 3'h0, 2'h3);
          acc(3'h0, 32'h0001_2348, k[1:0]);
          compare("timing length", n, exp_n(c[3:0], k[1:0], 2'h0, 1'b0));
        end
    // turn-off counts over all access kinds, on a timing with its own turn-off
    for (int t = 0; t < 4; t++)
    begin
      load(3'h0, CT_EDO_2, t[1:0], 1'b0, 3'h0, 2'h3);
      for (int k = 0; k < 4; k++)
      begin
        acc(3'h0, 32'hA5C3_1F08, k[1:0]);
        compare("turn-off length", n, exp_n(CT_EDO_2, k[1:0], t[1:0], 1'b0));
        compare("row word", row_ad, {30'h0, k[1:0], 32'hA5C3_1F08});
        compare("row drive", row_oe, 1'b1);
        compare("row cycles", rows, 1);
        compare("column drive", col_oe, k == 1);
        if (k == 1)
          compare("write data", col_ad, {32'h5A3C_E0F7, 32'hA5C3_1F08});
      end
    end
    // every shift and width
    for (int s = 0; s < 8; s++)
      for (int w = 0; w < 4; w++)
      begin
        load(3'h4, CT_SSRAM_1, 2'h0, 1'b0, s[2:0], w[1:0]);
        acc(3'h4, 32'hDEAD_BEEF, KIND_WRITE);
        n = (s == 0) ? w : 7 + s + w;
        compare("row lines", row_rca, 17'(32'hDEAD_BEEF >> n));
        compare("column lines", col_rca, 17'(32'hDEAD_BEEF >> w));
      end
    // exception codes with the enable set and clear
    load(3'h2, CT_EDO_PIPE1, 2'h0, 1'b1, 3'h0, 2'h3);
    load(3'h3, CT_EDO_PIPE1, 2'h0, 1'b0, 3'h0, 2'h3);
    for (int f = 0; f < 4; f++)
    begin
      fault_code = f[1:0];
      acc(3'h2, 32'h40, KIND_WRITE);
      compare("enabled end", {end_kind, n[7:0]}, (f == 0) ? 11'h106 : 11'h405);
      compare("enabled columns", cols, (f == 0) ? 1 : 0);
      if (f != 0)
        compare("fault code", exc_code, f[1:0]);
      acc(3'h3, 32'h40, KIND_WRITE);
      compare("disabled end", {end_kind, n[7:0]}, 11'h103);
      compare("disabled columns", cols, 1);
    end
    fault_code = 2'h0;
    // two banks back to back, prompt and slow read data
    load(3'h2, CT_EDO_3, 2'h3, 1'b0, 3'h0, 2'h3);
    load(3'h5, CT_SD_BL1_L4, 2'h1, 1'b0, 3'h0, 2'h3);
    for (int i = 0; i < 4; i++)
    begin
      slow = i[0];
      mem_word = {32'h1234_5678, i};
      acc(i[0] ? 3'h5 : 3'h2, 32'h100, KIND_READ);
      compare("bank length", n, i[0] ? exp_n(CT_SD_BL1_L4, 2'h0, 2'h1, 1'b0)
        : exp_n(CT_EDO_3, 2'h0, 2'h3, 1'b0));
      compare("column cycles", cols, i[0] ? 4 : 3);
      compare("read data", rd_data, mem_word ^ 64'(32'h100 >> 3));
    end
    complete_run();
  end
endmodule // tb_top
